// file: rtl/wlk_cmd.sv
`timescale 1ns/100ps
// Operation
// - failed byte program sets program error flag
// - opcode 06h sets latch at select rise
// - program, otp, rmw refused without latch
// - erase and status writes refused without latch
// - opcodes eight clocks, msb first
// - select rise off byte boundary aborts
// - 06h, 04h, 50h are opcode only
// - opcode 04h clears latch at select rise
// - 50h arms only next volatile status write
// - 36h: opcode plus 24 address bits
// - valid lock sets bit, clears latch
// - lock needs latch set beforehand
// - lock bits protect only when select bit set
// - reset sets every block lock bit
// - 39h clears addressed bit in select mode
// - unlock same format, also clears latch
// - lock bit covers enclosing 4 kB block
// - program run or abort clears latch
module wlk_cmd
    import wlk_pkg::*;
(
    // core clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // spi link pins
    input  wire logic                 spi_sck,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_mosi,
    // program engine events (core domain)
    input  wire logic                 prog_byte_fail,
    input  wire logic                 prog_end,
    input  wire logic                 error_flag_clear,
    // protection configuration (core domain)
    input  wire logic                 block_protect_select,
    input  wire logic                 range_protected,
    input  wire logic [23:0]          query_addr,
    // state
    output logic                      write_enable_latch,
    output logic                      program_error_flag,
    output logic                      vol_status_armed,
    output logic [LOCK_BITS-1:0]      lock_bits,
    output logic                      query_protected,
    // gated command hand-off
    output logic                      gated_go,
    output logic                      gated_refused,
    output logic                      gated_volatile,
    output logic [7:0]                gated_opcode,
    output logic [23:0]               gated_addr
);

    // ---- link domain ----
    logic                  frame_clr;
    logic                  first_q;
    logic                  frame_tog_q;
    logic [5:0]            cnt_q;
    logic [2:0]            phase_q;
    logic [SHIFT_BITS-1:0] sh_q;
    logic [7:0]            op_q;

    // raised by select high, so the next clock knows a frame begins
    assign frame_clr = rst | spi_cs_n;

    always_ff @(posedge spi_sck or posedge frame_clr)
    begin
        if (frame_clr)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    // one toggle per frame tells the core a fresh frame was seen
    always_ff @(posedge spi_sck or posedge rst)
    begin
        if (rst)
            frame_tog_q <= 1'b0;
        else if (first_q)
            frame_tog_q <= ~frame_tog_q;
    end

    // bit count saturates; phase tracks position inside a byte
    always_ff @(posedge spi_sck or posedge rst)
    begin
        if (rst)
        begin
            cnt_q   <= '0;
            phase_q <= PHASE_ALIGN;
        end
        else if (first_q)
        begin
            cnt_q   <= CNT_ONE;
            phase_q <= PHASE_ONE;
        end
        else
        begin
            if (cnt_q != CNT_FULL)
                cnt_q <= cnt_q + CNT_ONE;
            phase_q <= phase_q + PHASE_ONE;
        end
    end

    // msb first shift, frozen once opcode plus address are in
    always_ff @(posedge spi_sck or posedge rst)
    begin
        if (rst)
            sh_q <= '0;
        else if (first_q)
            sh_q <= {{(SHIFT_BITS-1){1'b0}}, spi_mosi};
        else if (cnt_q != CNT_FULL)
            sh_q <= {sh_q[SHIFT_BITS-2:0], spi_mosi};
    end

    // opcode latched on its eighth bit; later bits never touch it
    always_ff @(posedge spi_sck or posedge rst)
    begin
        if (rst)
            op_q <= '0;
        else if (!first_q && cnt_q == CNT_OP_LAST)
            op_q <= {sh_q[OP_BITS-2:0], spi_mosi};
    end

    // ---- crossing into core domain ----
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_seen_q;

    // two stages per level; third stage only for edge detect
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
        end
        else
        begin
            cs_s1_q  <= spi_cs_n;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            tog_s1_q <= frame_tog_q;
            tog_s2_q <= tog_s1_q;
        end
    end

    // link words are read only after select is high and sck idle,
    // so they are quasi-static; the host must hold select high
    // for a few core cycles before the next frame's first clock
    logic cs_rise;
    logic frame_new;
    logic aligned;
    logic has_op;
    logic has_addr;
    logic done;
    logic [7:0]       opc;
    logic [BLK_W-1:0] blk_idx;

    assign cs_rise   = cs_s2_q & ~cs_s3_q;
    assign frame_new = tog_s2_q != tog_seen_q;
    assign aligned   = phase_q == PHASE_ALIGN;
    assign has_op    = cnt_q >= CNT_OP_DONE;
    assign has_addr  = cnt_q == CNT_FULL;
    assign done      = cs_rise & frame_new & aligned & has_op;
    assign opc       = op_q;
    // low twelve address bits never pick the block
    assign blk_idx   = sh_q[BLK_LSB+BLK_W-1:BLK_LSB];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            tog_seen_q <= 1'b0;
        else if (cs_rise)
            tog_seen_q <= tog_s2_q;
    end

    // decoded actions of a completed frame
    logic do_wren;
    logic do_wrdi;
    logic do_vol;
    logic do_lock;
    logic do_unlock;
    logic gated_cmd;

    // opcode-only commands act on any aligned length
    assign do_wren   = done && opc == OP_WREN;
    assign do_wrdi   = done && opc == OP_WRDI;
    assign do_vol    = done && opc == OP_VOL_EN;
    // lock edits need full address, latch and select mode
    assign do_lock   = done && opc == OP_BLK_LOCK && has_addr
                       && write_enable_latch
                       && block_protect_select;
    assign do_unlock = done && opc == OP_BLK_ULCK && has_addr
                       && write_enable_latch
                       && block_protect_select;
    assign gated_cmd = done && wlk_is_gated(opc);

    // write enable latch: setting wins over any clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            write_enable_latch <= WEL_RST;
        else if (do_wren)
            write_enable_latch <= 1'b1;
        else if (do_wrdi)
            write_enable_latch <= 1'b0;
        else if (do_lock || do_unlock)
            write_enable_latch <= 1'b0;
        else if (prog_end)
            write_enable_latch <= 1'b0;
    end

    // volatile arm lasts for one following command only
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            vol_status_armed <= 1'b0;
        else if (do_vol)
            vol_status_armed <= 1'b1;
        else if (done)
            vol_status_armed <= 1'b0;
    end

    // sticky error; a failure in the clear cycle still lands
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            program_error_flag <= 1'b0;
        else if (prog_byte_fail)
            program_error_flag <= 1'b1;
        else if (error_flag_clear)
            program_error_flag <= 1'b0;
    end

    // one lock bit per block, all locked out of reset
    genvar gi;
    generate
        for (gi = 0; gi < LOCK_BITS; gi++)
        begin : g_lock
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    lock_bits[gi] <= LOCK_RST;
                else if (do_lock && blk_idx == BLK_W'(gi))
                    lock_bits[gi] <= 1'b1;
                else if (do_unlock && blk_idx == BLK_W'(gi))
                    lock_bits[gi] <= 1'b0;
            end
        end
    endgenerate

    // gated command hand-off to the program and erase engines
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            gated_go       <= 1'b0;
            gated_refused  <= 1'b0;
            gated_volatile <= 1'b0;
        end
        else
        begin
            gated_go       <= gated_cmd && write_enable_latch;
            gated_refused  <= gated_cmd && !write_enable_latch;
            gated_volatile <= gated_cmd && write_enable_latch
                              && opc == OP_STAT_WR
                              && vol_status_armed;
        end
    end

    // opcode and address held until the next gated command
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            gated_opcode <= '0;
            gated_addr   <= '0;
        end
        else if (gated_cmd)
        begin
            gated_opcode <= opc;
            gated_addr   <= sh_q[ADDR_BITS-1:0];
        end
    end

    // block of the queried address, low twelve bits ignored
    logic [BLK_W-1:0] q_idx;
    assign q_idx = query_addr[BLK_LSB+BLK_W-1:BLK_LSB];

    // protection of the queried address, registered
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            query_protected <= 1'b1;
        else if (block_protect_select)
            query_protected <= lock_bits[q_idx];
        else
            query_protected <= range_protected;
    end

endmodule

// file: rtl/wlk_pkg.sv
package wlk_pkg;
    // opcodes handled or gated here
    localparam logic [7:0] OP_WREN      = 8'h06;
    localparam logic [7:0] OP_WRDI      = 8'h04;
    localparam logic [7:0] OP_VOL_EN    = 8'h50;
    localparam logic [7:0] OP_BLK_LOCK  = 8'h36;
    localparam logic [7:0] OP_BLK_ULCK  = 8'h39;
    localparam logic [7:0] OP_STAT_WR   = 8'h01;
    localparam logic [7:0] OP_STAT_WR2  = 8'h31;
    localparam logic [7:0] OP_STAT_WR3  = 8'h11;
    localparam logic [7:0] OP_STAT_WR4  = 8'h71;
    localparam logic [7:0] OP_PROG      = 8'h02;
    localparam logic [7:0] OP_PROG_DUAL = 8'hA2;
    localparam logic [7:0] OP_PROG_QUAD = 8'h32;
    localparam logic [7:0] OP_SEQ_A     = 8'hAF;
    localparam logic [7:0] OP_SEQ_B     = 8'hAD;
    localparam logic [7:0] OP_BUF_PROG  = 8'h88;
    localparam logic [7:0] OP_ER_PAGE   = 8'h81;
    localparam logic [7:0] OP_ER_DB     = 8'hDB;
    localparam logic [7:0] OP_ER_4K     = 8'h20;
    localparam logic [7:0] OP_ER_32K    = 8'h52;
    localparam logic [7:0] OP_ER_64K    = 8'hD8;
    localparam logic [7:0] OP_ER_CHIP_A = 8'h60;
    localparam logic [7:0] OP_ER_CHIP_B = 8'hC7;
    localparam logic [7:0] OP_OTP_PROG  = 8'h9B;
    localparam logic [7:0] OP_RMW       = 8'h0A;

    // frame geometry
    localparam int         OP_BITS      = 8;
    localparam int         ADDR_BITS    = 24;
    localparam int         SHIFT_BITS   = 32;
    localparam logic [5:0] CNT_OP_DONE  = 6'h08;
    localparam logic [5:0] CNT_OP_LAST  = 6'h07;
    localparam logic [5:0] CNT_FULL     = 6'h20;
    localparam logic [5:0] CNT_ONE      = 6'h01;
    localparam logic [2:0] PHASE_ONE    = 3'h1;
    localparam logic [2:0] PHASE_ALIGN  = 3'h0;

    // lock map: one bit per 4 kB block of the array
    localparam int         LOCK_BITS    = 128;
    localparam int         BLK_LSB      = 12;
    localparam int         BLK_W        = 7;
    localparam logic       LOCK_RST     = 1'b1;
    localparam logic       WEL_RST      = 1'b0;

    // commands that need the write enable latch
    function automatic logic wlk_is_gated(input logic [7:0] op);
        case (op)
            OP_PROG, OP_PROG_DUAL, OP_PROG_QUAD, OP_SEQ_A, OP_SEQ_B,
            OP_BUF_PROG, OP_ER_PAGE, OP_ER_DB, OP_ER_4K, OP_ER_32K,
            OP_ER_64K, OP_ER_CHIP_A, OP_ER_CHIP_B, OP_OTP_PROG,
            OP_STAT_WR, OP_STAT_WR2, OP_STAT_WR3, OP_STAT_WR4,
            OP_RMW:  wlk_is_gated = 1'b1;
            default: wlk_is_gated = 1'b0;
        endcase
    endfunction
endpackage

// file: dv/wlk_cmd_asserts.sv
`timescale 1ns/100ps
module wlk_cmd_asserts
    import wlk_pkg::*;
(
    // clock and reset
    input logic                 core_clk,
    input logic                 rst,
    // core side inputs
    input logic                 prog_byte_fail,
    input logic                 prog_end,
    input logic                 error_flag_clear,
    input logic                 block_protect_select,
    input logic                 range_protected,
    input logic [23:0]          query_addr,
    // state and hand-off
    input logic                 write_enable_latch,
    input logic                 program_error_flag,
    input logic                 vol_status_armed,
    input logic [LOCK_BITS-1:0] lock_bits,
    input logic                 query_protected,
    input logic                 gated_go,
    input logic                 gated_refused,
    input logic                 gated_volatile,
    input logic [7:0]           gated_opcode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic qexp_q;

    // expected protection answer, one cycle behind its inputs
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            qexp_q <= 1'b1;
        else
            qexp_q <= block_protect_select ? lock_bits[query_addr[18:12]]
                                           : range_protected;
    end

    property p_go_wel;
        gated_go |-> $past(write_enable_latch) && !gated_refused;
    endproperty
    a_go_wel: assert property (p_go_wel)
        else $error("gated command accepted without latch");
    property p_ref_wel;
        gated_refused |-> !$past(write_enable_latch);
    endproperty
    a_ref_wel: assert property (p_ref_wel)
        else $error("gated command refused with latch set");
    property p_vol;
        gated_volatile |-> gated_go && gated_opcode == OP_STAT_WR
                           && $past(vol_status_armed, 2);
    endproperty
    a_vol: assert property (p_vol)
        else $error("volatile write without arm");
    property p_err_set;
        prog_byte_fail |=> program_error_flag;
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("program error flag not set");
    property p_err_hold;
        program_error_flag && !error_flag_clear |=> program_error_flag;
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("program error flag lost");
    property p_end_clr;
        prog_end && write_enable_latch |=> !write_enable_latch;
    endproperty
    a_end_clr: assert property (p_end_clr)
        else $error("latch kept after program end");
    property p_lock_up;
        (lock_bits & ~$past(lock_bits)) != '0
            |-> $fell(write_enable_latch) && $past(block_protect_select);
    endproperty
    a_lock_up: assert property (p_lock_up)
        else $error("lock bit set without latch or mode");
    property p_lock_dn;
        (~lock_bits & $past(lock_bits)) != '0
            |-> $fell(write_enable_latch) && $past(block_protect_select);
    endproperty
    a_lock_dn: assert property (p_lock_dn)
        else $error("lock bit cleared without latch or mode");
    property p_query;
        !$past(rst) |-> query_protected == qexp_q;
    endproperty
    a_query: assert property (p_query)
        else $error("protection answer wrong");

    // main scenarios reached
    c_go: cover property (gated_go);
    c_ref: cover property (gated_refused);
    c_vol: cover property (gated_volatile);
endmodule

bind wlk_cmd wlk_cmd_asserts chk_i (.core_clk, .rst, .prog_byte_fail,
    .prog_end, .error_flag_clear, .block_protect_select, .range_protected,
    .query_addr, .write_enable_latch, .program_error_flag,
    .vol_status_armed, .lock_bits, .query_protected, .gated_go,
    .gated_refused, .gated_volatile, .gated_opcode);

// file: dv/wlk_host.sv
`timescale 1ns/100ps
module wlk_host
(
    // link pins
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi
);
    // idle: sck parked low, select high; one driving process only
    task automatic park;
        spi_sck  = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    endtask

    // n bits of w msb first; n under the full count cuts it short
    task automatic frame(input logic [39:0] w, input int n);
        spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spi_mosi = w[39-i];
            #6 spi_sck = 1'b1;
            #6 spi_sck = 1'b0;
        end
        #3 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi; // released line must not hold old bit
        #40; // select-high gap, long enough for the core to act
    endtask
endmodule

// file: dv/test_write_enable_and_block_lock_cmds.sv
`timescale 1ns/100ps
module test_write_enable_and_block_lock_cmds;
    import wlk_pkg::*;
    logic                 core_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 spi_sck, spi_cs_n, spi_mosi;
    logic                 prog_byte_fail = 1'b0, prog_end = 1'b0;
    logic                 error_flag_clear = 1'b0, range_protected = 1'b1;
    logic                 block_protect_select = 1'b0;
    logic [23:0]          query_addr = 24'h00_5000;
    logic                 write_enable_latch, program_error_flag;
    logic                 vol_status_armed, query_protected;
    logic [LOCK_BITS-1:0] lock_bits;
    logic                 gated_go, gated_refused, gated_volatile;
    logic [7:0]           gated_opcode;
    logic [23:0]          gated_addr;
    int                   n_go = 0, n_ref = 0, n_vol = 0;
    int                   go_d, ref_d, vol_d;
    int                   errors = 0;
    int                   total_checks = 0;
    logic [7:0]           gops [19] = '{OP_PROG, OP_PROG_DUAL, OP_PROG_QUAD,
        OP_SEQ_A, OP_SEQ_B, OP_BUF_PROG, OP_ER_PAGE, OP_ER_DB, OP_ER_4K,
        OP_ER_32K, OP_ER_64K, OP_ER_CHIP_A, OP_ER_CHIP_B, OP_OTP_PROG,
        OP_STAT_WR, OP_STAT_WR2, OP_STAT_WR3, OP_STAT_WR4, OP_RMW};

    // core clock, 4 ns
    always #2 core_clk = ~core_clk;

    wlk_host host (.spi_sck, .spi_cs_n, .spi_mosi);
    wlk_cmd dut (.core_clk, .rst, .spi_sck, .spi_cs_n, .spi_mosi,
        .prog_byte_fail, .prog_end, .error_flag_clear, .block_protect_select,
        .range_protected, .query_addr, .write_enable_latch,
        .program_error_flag, .vol_status_armed, .lock_bits, .query_protected,
        .gated_go, .gated_refused, .gated_volatile, .gated_opcode,
        .gated_addr);

    // pulses counted, so each frame's task sees what it raised
    always @(posedge core_clk)
    begin
        if (gated_go) n_go <= n_go + 1;
        if (gated_refused) n_ref <= n_ref + 1;
        if (gated_volatile) n_vol <= n_vol + 1;
    end

    task automatic chk(input string nm, input logic [127:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic send(input logic [7:0] op, input logic [23:0] a, int n);
        int g0, r0, v0;
        g0 = n_go;
        r0 = n_ref;
        v0 = n_vol;
        host.frame({op, a, 8'h00}, n);
        go_d = n_go - g0;
        ref_d = n_ref - r0;
        vol_d = n_vol - v0;
    endtask

    task automatic op8(input logic [7:0] op);
        send(op, 24'h00_0000, 8);
    endtask

    task automatic end_pgm;
        @(posedge core_clk);
        prog_end <= 1'b1;
        @(posedge core_clk);
        prog_end <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic t_latch;
        chk("locks", {LOCK_BITS{1'b1}}, lock_bits);
        chk("wel", 1'b0, write_enable_latch);
        op8(OP_WREN);
        chk("wel", 1'b1, write_enable_latch);
        send(OP_WRDI, 24'h00_0000, 7);
        chk("wel", 1'b1, write_enable_latch);
        send(OP_WRDI, 24'h00_0000, 12);
        chk("wel", 1'b1, write_enable_latch);
        send(OP_WRDI, 24'hFF_0000, 16);
        chk("wel", 1'b0, write_enable_latch);
        send(OP_WREN, 24'hAB_CDEF, 32);
        chk("wel", 1'b1, write_enable_latch);
    endtask

    task automatic t_gated;
        for (int i = 0; i < 19; i++)
        begin
            op8(OP_WRDI);
            send(gops[i], 24'h12_3456, 32);
            chk("refused", 1, ref_d);
            chk("go", 0, go_d);
            chk("opcode", gops[i], gated_opcode);
            chk("addr", 24'h12_3456, gated_addr);
            op8(OP_WREN);
            send(gops[i], 24'h12_3456, 32);
            chk("go", 1, go_d);
            end_pgm();
            chk("wel", 1'b0, write_enable_latch);
        end
    endtask

    task automatic t_vol;
        op8(OP_WREN);
        op8(OP_VOL_EN);
        chk("wel", 1'b1, write_enable_latch);
        chk("armed", 1'b1, vol_status_armed);
        send(OP_STAT_WR, 24'h00_0000, 16);
        chk("vol", 1, vol_d);
        chk("armed", 1'b0, vol_status_armed);
        send(OP_STAT_WR, 24'h00_0000, 16);
        chk("vol", 0, vol_d);
        end_pgm();
    endtask

    task automatic t_lock;
        @(posedge core_clk);
        block_protect_select <= 1'b1;
        op8(OP_WREN);
        send(OP_BLK_ULCK, 24'h00_5ABC, 32);
        chk("locks", ~(128'h1 << 5), lock_bits);
        chk("wel", 1'b0, write_enable_latch);
        chk("qprot", 1'b0, query_protected);
        send(OP_BLK_LOCK, 24'h00_5FFF, 32);
        chk("locks", ~(128'h1 << 5), lock_bits);
        op8(OP_WREN);
        send(OP_BLK_LOCK, 24'h00_5FFF, 24);
        chk("locks", ~(128'h1 << 5), lock_bits);
        send(OP_BLK_LOCK, 24'h00_5FFF, 32);
        chk("locks", {LOCK_BITS{1'b1}}, lock_bits);
        chk("wel", 1'b0, write_enable_latch);
        @(posedge core_clk);
        block_protect_select <= 1'b0;
        range_protected <= 1'b0;
        op8(OP_WREN);
        send(OP_BLK_ULCK, 24'h00_5000, 32);
        chk("locks", {LOCK_BITS{1'b1}}, lock_bits);
        chk("qprot", 1'b0, query_protected);
    endtask

    task automatic t_err;
        @(posedge core_clk);
        prog_byte_fail <= 1'b1;
        @(posedge core_clk);
        prog_byte_fail <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("perr", 1'b1, program_error_flag);
        error_flag_clear <= 1'b1;
        @(posedge core_clk);
        error_flag_clear <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("perr", 1'b0, program_error_flag);
        // failure and clear in one cycle: the failure must land
        prog_byte_fail <= 1'b1;
        error_flag_clear <= 1'b1;
        @(posedge core_clk);
        prog_byte_fail <= 1'b0;
        error_flag_clear <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("perr", 1'b1, program_error_flag);
    endtask

    // mid-run reset relocks every block and drops the latch
    task automatic t_reset;
        @(posedge core_clk);
        block_protect_select <= 1'b1;
        op8(OP_WREN);
        send(OP_BLK_ULCK, 24'h00_3000, 32);
        chk("locks", ~(128'h1 << 3), lock_bits);
        op8(OP_WREN);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("locks", {LOCK_BITS{1'b1}}, lock_bits);
        chk("wel", 1'b0, write_enable_latch);
        chk("perr", 1'b0, program_error_flag);
        block_protect_select <= 1'b0;
    endtask

    task automatic close_out;
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        host.park();
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_latch();
        t_gated();
        t_vol();
        t_lock();
        t_err();
        t_reset();
        close_out();
    end

    // watchdog: the run needs roughly 27 us
    initial
    begin
        #200000;
        errors++;
        close_out();
    end
endmodule
